//--- include/nand_bus_pkg.sv
package nand_bus_pkg;

  typedef enum logic [1:0] {MODE_ASYNC, MODE_NVDDR, MODE_NVDDR2} iface_mode_e;

  localparam iface_mode_e MODE_RST = MODE_ASYNC;

  // array geometry
  localparam int unsigned PAGE_BYTES       = 18592;
  localparam int unsigned PAGES_PER_BLOCK  = 512;
  localparam int unsigned BLOCKS_PER_PLANE = 548;
  localparam int unsigned PLANE_COUNT      = 4;
  localparam logic [15:0] COL_LIMIT        = 16'h48A0;

  localparam logic [7:0] CMD_RESET = 8'hFF;

  // address cycle positions
  localparam logic [2:0] ADDR_COL_LO = 3'h0;
  localparam logic [2:0] ADDR_COL_HI = 3'h1;
  localparam logic [2:0] ADDR_ROW_0  = 3'h2;
  localparam logic [2:0] ADDR_ROW_1  = 3'h3;
  localparam logic [2:0] ADDR_ROW_2  = 3'h4;
  localparam int unsigned LUN_MSB    = 7;
  localparam int unsigned LUN_LSB    = 5;

  // status byte fields
  localparam int unsigned STAT_FAIL_BIT = 0;
  localparam int unsigned STAT_ARDY_BIT = 5;
  localparam int unsigned STAT_RDY_BIT  = 6;
  localparam int unsigned STAT_WP_BIT   = 7;

  // pin sampling vector positions
  localparam int unsigned PIN_W     = 18;
  localparam int unsigned PIN_DQ    = 0;
  localparam int unsigned PIN_ENUM  = 8;
  localparam int unsigned PIN_DQSC  = 9;
  localparam int unsigned PIN_DQS   = 10;
  localparam int unsigned PIN_WP    = 11;
  localparam int unsigned PIN_REC   = 12;
  localparam int unsigned PIN_RE    = 13;
  localparam int unsigned PIN_WE    = 14;
  localparam int unsigned PIN_ALE   = 15;
  localparam int unsigned PIN_CLE   = 16;
  localparam int unsigned PIN_CE    = 17;
  localparam logic [PIN_W-1:0] PIN_RST = 18'h3F800;

endpackage

//--- design/nand_flash_bus_interface.sv
`timescale 1ns/1ps
`default_nettype none
module nand_flash_bus_interface
  import nand_bus_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        re_c,
  input  wire logic        wp_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  input  wire logic        dqs_in,
  output logic             dqs_out,
  output logic             dqs_oe,
  input  wire logic        dqs_c_in,
  output logic             dqs_c_out,
  output logic             dqs_c_oe,
  output logic             rb_n_out,
  output logic             rb_n_oe,
  input  wire logic        chain_enum_in,
  output logic             chain_enum_out,
  input  wire iface_mode_e mode_sel,
  input  wire logic        mode_load,
  input  wire logic        diff_en,
  input  wire logic        odt_en_req,
  input  wire logic [7:0]  lun_busy,
  input  wire logic [7:0]  lun_fail,
  input  wire logic [7:0]  rd_data,
  output logic             cmd_valid,
  output logic      [7:0]  cmd_byte,
  output logic             addr_valid,
  output logic      [7:0]  addr_byte,
  output logic      [2:0]  addr_index,
  output logic             addr_is_row,
  output logic      [15:0] col_addr,
  output logic      [23:0] row_addr,
  output logic             col_bad,
  output logic      [2:0]  lun_sel,
  output logic             wr_valid,
  output logic      [7:0]  wr_byte,
  output logic             rd_take,
  output logic      [7:0]  status_byte,
  output logic             array_write_allow,
  output logic             odt_on,
  output var iface_mode_e  iface_mode,
  output logic             bus_idle
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  function automatic logic fall(input logic cur, input logic prev);
    fall = ~cur & prev;
  endfunction

  // pin synchronisers
  logic [PIN_W-1:0] meta_reg;
  logic [PIN_W-1:0] pin_reg;
  logic [PIN_W-1:0] prev_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= PIN_RST;
      pin_reg  <= PIN_RST;
      prev_reg <= PIN_RST;
    end else if (clk_en) begin
      meta_reg <= {ce_n, cle, ale, we_n, re_n, re_c, wp_n, dqs_in, dqs_c_in, chain_enum_in, dq_in};
      pin_reg  <= meta_reg;
      prev_reg <= pin_reg;
    end
  end

  logic       s_ce_n, s_cle, s_ale, s_we, s_re, s_rec, s_wp, s_dqs, s_dqsc, s_enum;
  logic [7:0] s_dq;
  logic       p_we, p_re, p_dqs;

  assign s_ce_n = pin_reg[PIN_CE];
  assign s_cle  = pin_reg[PIN_CLE];
  assign s_ale  = pin_reg[PIN_ALE];
  assign s_we   = pin_reg[PIN_WE];
  assign s_re   = pin_reg[PIN_RE];
  assign s_rec  = pin_reg[PIN_REC];
  assign s_wp   = pin_reg[PIN_WP];
  assign s_dqs  = pin_reg[PIN_DQS];
  assign s_dqsc = pin_reg[PIN_DQSC];
  assign s_enum = pin_reg[PIN_ENUM];
  assign s_dq   = pin_reg[PIN_DQ+7:PIN_DQ];
  assign p_we   = prev_reg[PIN_WE];
  assign p_re   = prev_reg[PIN_RE];
  assign p_dqs  = prev_reg[PIN_DQS];

  iface_mode_e mode_reg, mode_next;
  logic        cmd_valid_reg, cmd_valid_next;
  logic [7:0]  cmd_byte_reg, cmd_byte_next;
  logic        addr_valid_reg, addr_valid_next;
  logic [7:0]  addr_byte_reg, addr_byte_next;
  logic [2:0]  addr_index_reg, addr_index_next;
  logic        addr_is_row_reg, addr_is_row_next;
  logic [2:0]  addr_cnt_reg, addr_cnt_next;
  logic [15:0] col_reg, col_next;
  logic [23:0] row_reg, row_next;
  logic        col_bad_reg, col_bad_next;
  logic [2:0]  lun_sel_reg, lun_sel_next;
  logic        wr_valid_reg, wr_valid_next;
  logic [7:0]  wr_byte_reg, wr_byte_next;
  logic        rd_take_reg, rd_take_next;
  logic        rd_phase_reg, rd_phase_next;
  logic [7:0]  dq_out_reg, dq_out_next;
  logic        dq_oe_reg, dq_oe_next;
  logic        dqs_out_reg, dqs_out_next;
  logic        dqs_oe_reg, dqs_oe_next;
  logic        dqs_c_out_reg, dqs_c_out_next;
  logic        dqs_c_oe_reg, dqs_c_oe_next;
  logic        rb_n_oe_reg, rb_n_oe_next;
  logic        enum_reg, enum_next;
  logic [7:0]  status_reg, status_next;
  logic        wr_allow_reg, wr_allow_next;
  logic        odt_reg, odt_next;
  logic        idle_reg, idle_next;

  logic sel, we_r, re_f, re_e, dqs_e, diff_on, dqs_ok, re_ok;
  logic cmd_cyc, adr_cyc, ca_strobe, drive, take, busy_sel;

  always_comb begin
    sel       = !s_ce_n;
    we_r      = rise(s_we, p_we);
    re_f      = fall(s_re, p_re);
    re_e      = rise(s_re, p_re) | fall(s_re, p_re);
    dqs_e     = rise(s_dqs, p_dqs) | fall(s_dqs, p_dqs);
    diff_on   = diff_en && (mode_reg == MODE_NVDDR2);
    dqs_ok    = !diff_on || (s_dqs != s_dqsc);
    re_ok     = !diff_on || (s_re != s_rec);
    // both latches high never a command or address
    cmd_cyc   = s_cle && !s_ale;
    adr_cyc   = s_ale && !s_cle;
    // clock edge in NV-DDR, else write strobe with read enable high
    ca_strobe = sel && we_r && ((mode_reg == MODE_NVDDR) || s_re);
    busy_sel  = lun_busy[lun_sel_reg];
    drive     = 1'b0;
    take      = 1'b0;

    mode_next        = mode_reg;
    cmd_valid_next   = 1'b0;
    cmd_byte_next    = cmd_byte_reg;
    addr_valid_next  = 1'b0;
    addr_byte_next   = addr_byte_reg;
    addr_index_next  = addr_index_reg;
    addr_is_row_next = addr_is_row_reg;
    addr_cnt_next    = addr_cnt_reg;
    col_next         = col_reg;
    row_next         = row_reg;
    lun_sel_next     = lun_sel_reg;
    wr_valid_next    = 1'b0;
    wr_byte_next     = wr_byte_reg;
    rd_take_next     = 1'b0;
    rd_phase_next    = rd_phase_reg && sel;
    dq_out_next      = dq_out_reg;
    dqs_out_next     = dqs_out_reg;

    if (mode_load) begin
      mode_next     = mode_sel;
      rd_phase_next = 1'b0;
    end

    if (ca_strobe && cmd_cyc) begin
      cmd_valid_next = 1'b1;
      cmd_byte_next  = s_dq;
      addr_cnt_next  = ADDR_COL_LO;
      rd_phase_next  = 1'b0;
    end else if (ca_strobe && adr_cyc) begin
      addr_valid_next  = 1'b1;
      addr_byte_next   = s_dq;
      addr_index_next  = addr_cnt_reg;
      addr_is_row_next = addr_cnt_reg >= ADDR_ROW_0;
      rd_phase_next    = 1'b0;
      unique case (addr_cnt_reg)
        ADDR_COL_LO: col_next[7:0]   = s_dq;
        ADDR_COL_HI: col_next[15:8]  = s_dq;
        ADDR_ROW_0:  row_next[7:0]   = s_dq;
        ADDR_ROW_1:  row_next[15:8]  = s_dq;
        default: begin
          row_next[23:16] = s_dq;
          lun_sel_next    = s_dq[LUN_MSB:LUN_LSB];
        end
      endcase
      if (addr_cnt_reg < ADDR_ROW_2) begin
        addr_cnt_next = addr_cnt_reg + 3'h1;
      end
    end

    unique case (mode_reg)
      MODE_ASYNC: begin
        // write enable rising edge takes data
        if (sel && we_r && s_re && !s_cle && !s_ale) begin
          wr_valid_next = 1'b1;
          wr_byte_next  = s_dq;
        end
        // read enable falling edge gives next byte
        take  = sel && re_f && s_we && !s_cle && !s_ale;
        drive = sel && !s_re && s_we && !s_cle && !s_ale;
      end
      MODE_NVDDR: begin
        // host strobe edges carry write data
        if (sel && s_cle && s_ale && s_re && dqs_e) begin
          wr_valid_next = 1'b1;
          wr_byte_next  = s_dq;
        end
        take  = sel && s_cle && s_ale && !s_re && we_r;
        // direction select low hands bus to device
        drive = sel && !s_re;
      end
      MODE_NVDDR2: begin
        // own read strobe never taken as write
        if (sel && !s_cle && !s_ale && s_re && s_we && dqs_e && dqs_ok && !rd_phase_reg) begin
          wr_valid_next = 1'b1;
          wr_byte_next  = s_dq;
        end
        take = sel && !s_cle && !s_ale && s_we && re_e && re_ok;
        if (take) begin
          rd_phase_next = 1'b1;
        end
        drive = sel && (rd_phase_reg || take);
      end
      default: begin
        drive = 1'b0;
      end
    endcase

    if (take) begin
      rd_take_next = 1'b1;
      dq_out_next  = rd_data;
      // device strobe toggles with each read byte in NV-DDR and NV-DDR2
      dqs_out_next = !dqs_out_reg;
    end
    // strobe idle and tri-stated in asynchronous mode
    if (!drive || (mode_reg == MODE_ASYNC)) begin
      dqs_out_next = 1'b0;
    end
    dq_oe_next     = drive;
    dqs_oe_next    = drive && (mode_reg != MODE_ASYNC);
    dqs_c_out_next = !dqs_out_next;
    dqs_c_oe_next  = dqs_oe_next && diff_on;

    col_bad_next  = col_reg >= COL_LIMIT;
    rb_n_oe_next  = |lun_busy;
    enum_next     = s_enum;
    // write protect gates program and erase
    wr_allow_next = s_wp;
    odt_next      = (mode_reg == MODE_NVDDR2) && odt_en_req && sel;
    idle_next     = sel && s_we && s_re;
    // status of the selected logical unit
    status_next                = 8'h00;
    status_next[STAT_FAIL_BIT] = lun_fail[lun_sel_reg];
    status_next[STAT_ARDY_BIT] = !busy_sel;
    status_next[STAT_RDY_BIT]  = !busy_sel;
    status_next[STAT_WP_BIT]   = s_wp;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_reg        <= MODE_RST;
      cmd_valid_reg   <= 1'b0;
      cmd_byte_reg    <= 8'h00;
      addr_valid_reg  <= 1'b0;
      addr_byte_reg   <= 8'h00;
      addr_index_reg  <= 3'h0;
      addr_is_row_reg <= 1'b0;
      addr_cnt_reg    <= 3'h0;
      col_reg         <= 16'h0000;
      row_reg         <= 24'h000000;
      col_bad_reg     <= 1'b0;
      lun_sel_reg     <= 3'h0;
      wr_valid_reg    <= 1'b0;
      wr_byte_reg     <= 8'h00;
      rd_take_reg     <= 1'b0;
      rd_phase_reg    <= 1'b0;
      dq_out_reg      <= 8'h00;
      dq_oe_reg       <= 1'b0;
      dqs_out_reg     <= 1'b0;
      dqs_oe_reg      <= 1'b0;
      dqs_c_out_reg   <= 1'b1;
      dqs_c_oe_reg    <= 1'b0;
      rb_n_oe_reg     <= 1'b0;
      enum_reg        <= 1'b0;
      status_reg      <= 8'h00;
      wr_allow_reg    <= 1'b0;
      odt_reg         <= 1'b0;
      idle_reg        <= 1'b0;
    end else if (clk_en) begin
      mode_reg        <= mode_next;
      cmd_valid_reg   <= cmd_valid_next;
      cmd_byte_reg    <= cmd_byte_next;
      addr_valid_reg  <= addr_valid_next;
      addr_byte_reg   <= addr_byte_next;
      addr_index_reg  <= addr_index_next;
      addr_is_row_reg <= addr_is_row_next;
      addr_cnt_reg    <= addr_cnt_next;
      col_reg         <= col_next;
      row_reg         <= row_next;
      col_bad_reg     <= col_bad_next;
      lun_sel_reg     <= lun_sel_next;
      wr_valid_reg    <= wr_valid_next;
      wr_byte_reg     <= wr_byte_next;
      rd_take_reg     <= rd_take_next;
      rd_phase_reg    <= rd_phase_next;
      dq_out_reg      <= dq_out_next;
      dq_oe_reg       <= dq_oe_next;
      dqs_out_reg     <= dqs_out_next;
      dqs_oe_reg      <= dqs_oe_next;
      dqs_c_out_reg   <= dqs_c_out_next;
      dqs_c_oe_reg    <= dqs_c_oe_next;
      rb_n_oe_reg     <= rb_n_oe_next;
      enum_reg        <= enum_next;
      status_reg      <= status_next;
      wr_allow_reg    <= wr_allow_next;
      odt_reg         <= odt_next;
      idle_reg        <= idle_next;
    end
  end

  assign dq_out            = dq_out_reg;
  assign dq_oe             = dq_oe_reg;
  assign dqs_out           = dqs_out_reg;
  assign dqs_oe            = dqs_oe_reg;
  assign dqs_c_out         = dqs_c_out_reg;
  assign dqs_c_oe          = dqs_c_oe_reg;
  // open drain: only ever pulls low
  assign rb_n_out          = 1'b0;
  assign rb_n_oe           = rb_n_oe_reg;
  assign chain_enum_out    = enum_reg;
  assign cmd_valid         = cmd_valid_reg;
  assign cmd_byte          = cmd_byte_reg;
  assign addr_valid        = addr_valid_reg;
  assign addr_byte         = addr_byte_reg;
  assign addr_index        = addr_index_reg;
  assign addr_is_row       = addr_is_row_reg;
  assign col_addr          = col_reg;
  assign row_addr          = row_reg;
  assign col_bad           = col_bad_reg;
  assign lun_sel           = lun_sel_reg;
  assign wr_valid          = wr_valid_reg;
  assign wr_byte           = wr_byte_reg;
  assign rd_take           = rd_take_reg;
  assign status_byte       = status_reg;
  assign array_write_allow = wr_allow_reg;
  assign odt_on            = odt_reg;
  assign iface_mode        = mode_reg;
  assign bus_idle          = idle_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !clk_en);

  chk_cmd_capture: assert property (
    ca_strobe && cmd_cyc |=> cmd_valid_reg && cmd_byte_reg == $past(s_dq) && !addr_valid_reg)
    else $error("command byte not captured");
  chk_addr_capture: assert property (
    ca_strobe && adr_cyc |=> addr_valid_reg && addr_byte_reg == $past(s_dq) && !cmd_valid_reg)
    else $error("address byte not captured");
  chk_deselect_quiet: assert property (
    s_ce_n |=> !cmd_valid_reg && !addr_valid_reg && !wr_valid_reg && !rd_take_reg && !dq_oe_reg)
    else $error("activity while deselected");
  chk_both_latch: assert property (
    s_cle && s_ale && mode_reg != MODE_NVDDR |=> !cmd_valid_reg && !addr_valid_reg)
    else $error("invalid latch combination accepted");
  chk_async_read: assert property (
    mode_reg == MODE_ASYNC && !s_ce_n && re_f && s_we && !s_cle && !s_ale
      |=> rd_take_reg && dq_out_reg == $past(rd_data) ##1 !rd_take_reg)
    else $error("read pulse did not present a byte");
  chk_sync_dir: assert property (
    mode_reg == MODE_NVDDR && dq_oe_reg |-> $past(s_re) == 1'b0 && $past(s_ce_n) == 1'b0)
    else $error("device drove bus against direction select");
  chk_dqs_async: assert property (
    (mode_reg == MODE_ASYNC)[*2] |-> !dqs_oe_reg && !dqs_c_oe_reg)
    else $error("strobe driven in asynchronous mode");
  chk_rb_busy: assert property (
    (|lun_busy) |=> rb_n_oe_reg ##1 (rb_n_oe_reg == $past(|lun_busy)))
    else $error("ready/busy not following array");
  chk_wp_block: assert property (
    !s_wp |=> !wr_allow_reg && !status_reg[STAT_WP_BIT])
    else $error("write protect not honoured");
  chk_odt_mode: assert property (
    odt_reg |-> $past(mode_reg) == MODE_NVDDR2)
    else $error("termination outside NV-DDR2");
  chk_lun_status: assert property (
    $past(resetn) && $past(clk_en) |-> status_reg[STAT_RDY_BIT] == !$past(busy_sel))
    else $error("status not from selected unit");
  chk_addr_route: assert property (
    addr_valid_reg |-> addr_is_row_reg == (addr_index_reg >= ADDR_ROW_0))
    else $error("address byte routed wrong");
  chk_enum_pass: assert property (
    $past(resetn) && $past(clk_en) |-> enum_reg == $past(s_enum))
    else $error("enumeration chain broken");
  chk_idle_bus: assert property (
    !s_ce_n && s_we && s_re && p_we && p_re && mode_reg == MODE_ASYNC |=> !cmd_valid_reg && !wr_valid_reg)
    else $error("latch during bus idle");
  chk_no_echo_write: assert property (
    mode_reg == MODE_NVDDR2 && rd_phase_reg |=> !wr_valid_reg)
    else $error("write taken from own read strobe");

  cov_cmd: cover property (cmd_valid_reg && cmd_byte_reg == CMD_RESET);
  cov_ddr_read: cover property (mode_reg == MODE_NVDDR && rd_take_reg ##[1:100] rd_take_reg);
  cov_ddr2_write: cover property (mode_reg == MODE_NVDDR2 && wr_valid_reg);
  cov_addr_full: cover property (addr_valid_reg && addr_index_reg == ADDR_ROW_2);

endmodule
`default_nettype wire

//--- bench/nand_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nand_host_model (
  input  wire logic       mclk,
  output logic            ce_n,
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            re_n,
  output logic            re_c,
  output logic            wp_n,
  output logic      [7:0] dq,
  output logic            dqs,
  output logic            dqs_c
);
  localparam int HALF = 20;
  initial begin
    {ce_n, we_n, re_n, wp_n, cle, ale, re_c, dqs} = 8'hF0;
    dqs_c = 1'b1;
    dq = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chip(input logic v);
    ce_n = v;
    hold(6);
  endtask
  task automatic protect(input logic v);
    wp_n = v;
    hold(8);
  endtask
  task automatic put(input logic c, input logic a, input logic [7:0] b);
    {cle, ale, dq} = {c, a, b};
    we_n = 1'b0;
    hold(HALF);
    we_n = 1'b1;
    hold(HALF);
    {cle, ale, dq} = {2'b00, ~b};
    hold(2);
  endtask
  task automatic get();
    {re_n, re_c} = 2'b01;
    hold(HALF);
    {re_n, re_c} = 2'b10;
    hold(HALF);
  endtask
  task automatic nv(input logic c, input logic a, input logic r, input logic [7:0] b, input int n);
    {cle, ale, re_n, re_c, dq} = {c, a, r, ~r, b};
    repeat (n) begin
      we_n = 1'b0;
      hold(HALF);
      we_n = 1'b1;
      hold(HALF);
    end
  endtask
  // host strobe edge carries write data; t, tc pick which strobe toggles
  task automatic strobe(input logic [7:0] b, input logic t, input logic tc);
    dq = b;
    hold(HALF);
    dqs = dqs ^ t;
    dqs_c = dqs_c ^ tc;
    hold(HALF);
  endtask
  // caller picks commands; no copyback or retry issued
endmodule
`default_nettype wire

//--- bench/nand_flash_bus_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module nand_flash_bus_interface_tb
  import nand_bus_pkg::*;
;
  logic        mclk, resetn, clk_en, mode_load, diff_en, odt_en_req, chain_enum_in;
  logic        ce_n, cle, ale, we_n, re_n, re_c, wp_n, dqs_h, dqs_c_h;
  logic [7:0]  dq_h, dq_in, dq_out, lun_busy, lun_fail, rd_data, cmd_byte, addr_byte, wr_byte, status_byte;
  logic        dq_oe, dqs_in, dqs_out, dqs_oe, dqs_c_in, dqs_c_out, dqs_c_oe, rb_n_out, rb_n_oe, rb_n;
  logic        chain_enum_out, cmd_valid, addr_valid, addr_is_row, col_bad, wr_valid, rd_take;
  logic        array_write_allow, odt_on, bus_idle, oe_seen;
  logic [2:0]  addr_index, lun_sel;
  logic [15:0] col_addr;
  logic [23:0] row_addr;
  iface_mode_e mode_sel, iface_mode;
  int          bad_count = 0, compares = 0, takes = 0, cmds = 0;
  logic [7:0]  ab [5] = '{8'hA0, 8'h48, 8'h11, 8'h22, 8'hE3};
  // pin levels from all enables, pull-up on ready/busy
  assign dq_in = dq_oe ? dq_out : dq_h;
  assign dqs_in = dqs_oe ? dqs_out : dqs_h;
  assign dqs_c_in = dqs_c_oe ? dqs_c_out : dqs_c_h;
  assign rb_n = rb_n_oe ? rb_n_out : 1'b1;
  nand_host_model u_host (.mclk, .ce_n, .cle, .ale, .we_n, .re_n, .re_c, .wp_n, .dq(dq_h), .dqs(dqs_h),
    .dqs_c(dqs_c_h));
  nand_flash_bus_interface u_dut (.mclk, .resetn, .clk_en, .ce_n, .cle, .ale, .we_n, .re_n, .re_c, .wp_n,
    .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe, .dqs_c_in, .dqs_c_out, .dqs_c_oe, .rb_n_out, .rb_n_oe,
    .chain_enum_in, .chain_enum_out, .mode_sel, .mode_load, .diff_en, .odt_en_req, .lun_busy, .lun_fail,
    .rd_data, .cmd_valid, .cmd_byte, .addr_valid, .addr_byte, .addr_index, .addr_is_row, .col_addr, .row_addr,
    .col_bad, .lun_sel, .wr_valid, .wr_byte, .rd_take, .status_byte, .array_write_allow, .odt_on, .iface_mode,
    .bus_idle);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    takes += rd_take;
    cmds += cmd_valid;
    oe_seen |= dq_oe;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic load(input iface_mode_e m);
    mode_sel = m;
    mode_load = 1'b1;
    @(negedge mclk);
    mode_load = 1'b0;
    wt(2);
  endtask
  task automatic complete_run();
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    {resetn, mode_load, diff_en, oe_seen} = 4'h0;
    {clk_en, odt_en_req, chain_enum_in} = 3'h7;
    mode_sel = MODE_ASYNC;
    {lun_busy, lun_fail, rd_data} = 24'h00005A;
    wt(12);
    resetn = 1'b1;
    wt(4);
    `CHK("mode", iface_mode, MODE_ASYNC)
    `CHK("dqs_oe", dqs_oe, 1'b0)
    u_host.chip(1'b0);
    u_host.put(1'b1, 1'b0, CMD_RESET);
    `CHK("cmd", cmd_byte, CMD_RESET)
    `CHK("idle", bus_idle, 1'b1)
    `CHK("odt", odt_on, 1'b0)
    foreach (ab[i]) u_host.put(1'b0, 1'b1, ab[i]);
    `CHK("col", col_addr, 16'h48A0)
    `CHK("row", row_addr, 24'hE32211)
    `CHK("idx", addr_index, 3'h4)
    `CHK("lun", lun_sel, 3'h7)
    `CHK("col_bad", col_bad, 1'b1)
    u_host.put(1'b1, 1'b0, 8'h00);
    u_host.put(1'b0, 1'b1, 8'h9F);
    u_host.put(1'b0, 1'b1, 8'h48);
    `CHK("col", col_addr, 16'h489F)
    `CHK("col_bad", col_bad, 1'b0)
    `CHK("is_row", addr_is_row, 1'b0)
    {lun_busy, lun_fail} = 16'h807F;
    wt(8);
    `CHK("rb", rb_n, 1'b0)
    `CHK("stat", status_byte, 8'h80)
    {lun_busy, lun_fail} = 16'h7F80;
    wt(8);
    `CHK("stat", status_byte, 8'hE1)
    u_host.protect(1'b0);
    `CHK("allow", array_write_allow, 1'b0)
    `CHK("stat", status_byte, 8'h61)
    u_host.protect(1'b1);
    `CHK("allow", array_write_allow, 1'b1)
    lun_busy = 8'h00;
    wt(8);
    `CHK("rb", rb_n, 1'b1)
    u_host.put(1'b0, 1'b0, 8'hC3);
    `CHK("wr", wr_byte, 8'hC3)
    u_host.get();
    rd_data = 8'hA5;
    u_host.get();
    `CHK("rd", dq_out, 8'hA5)
    `CHK("takes", takes, 2)
    `CHK("drive", oe_seen, 1'b1)
    `CHK("oe", dq_oe, 1'b0)
    lun_busy = 8'h01;
    u_host.chip(1'b1);
    {takes, cmds, oe_seen} = '0;
    u_host.put(1'b1, 1'b0, 8'h30);
    u_host.get();
    `CHK("cmds", cmds, 0)
    `CHK("takes", takes, 0)
    `CHK("drive", oe_seen, 1'b0)
    `CHK("rb", rb_n, 1'b0)
    lun_busy = 8'h00;
    u_host.chip(1'b0);
    u_host.put(1'b1, 1'b1, 8'h55);
    `CHK("cmds", cmds, 0)
    `CHK("addr", addr_byte, 8'h48)
    chain_enum_in = 1'b0;
    wt(8);
    `CHK("enum", chain_enum_out, 1'b0)
    clk_en = 1'b0;
    chain_enum_in = 1'b1;
    wt(8);
    `CHK("enum", chain_enum_out, 1'b0)
    clk_en = 1'b1;
    wt(8);
    `CHK("enum", chain_enum_out, 1'b1)
    load(MODE_NVDDR);
    `CHK("mode", iface_mode, MODE_NVDDR)
    `CHK("odt", odt_on, 1'b0)
    u_host.nv(1'b1, 1'b0, 1'b1, 8'h70, 1);
    u_host.nv(1'b0, 1'b0, 1'b1, 8'h00, 1);
    `CHK("cmd", cmd_byte, 8'h70)
    u_host.nv(1'b1, 1'b1, 1'b1, 8'h96, 1);
    u_host.strobe(8'h96, 1'b1, 1'b1);
    `CHK("wr", wr_byte, 8'h96)
    u_host.strobe(8'h69, 1'b1, 1'b1);
    `CHK("wr", wr_byte, 8'h69)
    takes = 0;
    u_host.nv(1'b1, 1'b1, 1'b0, 8'h00, 3);
    `CHK("takes", takes, 3)
    `CHK("dqs_oe", dqs_oe, 1'b1)
    `CHK("oe", dq_oe, 1'b1)
    u_host.nv(1'b0, 1'b0, 1'b1, 8'h00, 1);
    `CHK("oe", dq_oe, 1'b0)
    diff_en = 1'b1;
    load(MODE_NVDDR2);
    `CHK("odt", odt_on, 1'b1)
    odt_en_req = 1'b0;
    wt(8);
    `CHK("odt", odt_on, 1'b0)
    odt_en_req = 1'b1;
    u_host.put(1'b1, 1'b0, 8'h90);
    `CHK("cmd", cmd_byte, 8'h90)
    u_host.strobe(8'h3C, 1'b1, 1'b1);
    `CHK("wr", wr_byte, 8'h3C)
    u_host.strobe(8'hC5, 1'b1, 1'b1);
    `CHK("wr", wr_byte, 8'hC5)
    u_host.strobe(8'h77, 1'b1, 1'b0);
    `CHK("wr", wr_byte, 8'hC5)
    u_host.strobe(8'h77, 1'b0, 1'b1);
    takes = 0;
    u_host.get();
    `CHK("takes", takes, 2)
    `CHK("dqs_c_oe", dqs_c_oe, 1'b1)
    `CHK("dqs_out", dqs_out, 1'b0)
    `CHK("dqs_c_out", dqs_c_out, 1'b1)
    `CHK("wr", wr_byte, 8'hC5)
    u_host.chip(1'b1);
    `CHK("dqs_oe", dqs_oe, 1'b0)
    resetn = 1'b0;
    wt(2);
    resetn = 1'b1;
    wt(4);
    `CHK("mode", iface_mode, MODE_ASYNC)
    complete_run();
  end
endmodule
`default_nettype wire
